// File: src/wide_mode_pkg.sv
/*
 * Shared constants and carrier types for the wide-mode activation control
 * block: register offsets, field positions, reset values and size codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package wide_mode_pkg;

   // Register byte offsets
   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_CODE_SEG = 32'h0000_0004;
   localparam logic [31:0] OFS_PREFIX = 32'h0000_0008;
   localparam logic [31:0] OFS_MODE = 32'h0000_000c;
   localparam logic [31:0] OFS_PBASE_LO = 32'h0000_0010;
   localparam logic [31:0] OFS_PBASE_HI = 32'h0000_0014;
   localparam logic [31:0] OFS_INT_TABLE = 32'h0000_0018;
   localparam logic [31:0] OFS_FAULT = 32'h0000_001c;

   // Control register fields
   localparam int CTRL_ENABLE_POS = 0;
   localparam int CTRL_PAGING_POS = 1;
   localparam int CTRL_PAE_POS = 2;
   localparam int CTRL_ACTIVE_POS = 8;

   // Code segment attribute fields
   localparam int CS_LONG_POS = 0;
   localparam int CS_DSIZE_POS = 1;

   // Prefix override fields
   localparam int PFX_SHORT_POS = 0;
   localparam int PFX_WIDE_POS = 1;
   localparam int PFX_ADDR_POS = 2;

   // Mode status fields
   localparam int MODE_SUB_LSB = 0;
   localparam int MODE_ADDR_LSB = 2;
   localparam int MODE_OP_LSB = 4;
   localparam int MODE_RSV_POS = 6;
   localparam int MODE_DEF_ADDR_LSB = 8;
   localparam int MODE_DEF_OP_LSB = 10;

   // Fault status fields
   localparam int FLT_STICKY_POS = 0;
   localparam int FLT_CAUSE_LSB = 4;
   localparam int FLT_CODE_LSB = 8;
   localparam int FLT_COUNT_LSB = 16;

   // Size codes
   localparam logic [1:0] SIZE_16 = 2'h0;
   localparam logic [1:0] SIZE_32 = 2'h1;
   localparam logic [1:0] SIZE_64 = 2'h2;

   // Sub-mode codes
   localparam logic [1:0] SUB_LEGACY = 2'h0;
   localparam logic [1:0] SUB_COMPAT = 2'h1;
   localparam logic [1:0] SUB_64 = 2'h2;
   localparam logic [1:0] SUB_RESERVED = 2'h3;

   // Reset values and fixed codes
   localparam logic [63:0] RST_PAGE_BASE = 64'h0;
   localparam logic [31:0] RST_INT_TABLE = 32'h0;
   localparam logic [7:0] GP_ERROR_CODE = 8'h00;
   localparam logic [15:0] RST_FAULT_COUNT = 16'h0;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic default_size;
      logic long_attr;
   } code_seg_t;

   typedef struct packed {
      logic addr_short;
      logic op_wide;
      logic op_short;
   } prefix_t;

   typedef struct packed {
      logic reserved;
      logic [1:0] def_op;
      logic [1:0] def_addr;
      logic [1:0] op_size;
      logic [1:0] addr_size;
      logic [1:0] submode;
   } mode_info_t;

   // Keeps unstrobed byte lanes at their old value
   function automatic logic [31:0] strobe_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                                input logic [3:0] strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      return res;
   endfunction : strobe_merge

endpackage : wide_mode_pkg

// File: src/op_mode_decoder.sv
/*
 * Operating sub-mode and size decoder: maps the active bit, the code
 * segment attributes and the prefix overrides to sub-mode and sizes.
 * Assumes its inputs are registered state of the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module op_mode_decoder
   import wide_mode_pkg::*;
(
   // Mode state
   input wire logic i_active,
   input wire code_seg_t i_code_seg,
   input wire prefix_t i_prefix,
   // Decoded mode
   output mode_info_t o_mode
);

   always_comb begin
      o_mode = '0;
      if (!i_active) begin
         // Legacy: long attribute and wide prefix ignored
         o_mode.submode = SUB_LEGACY;
         o_mode.def_addr = i_code_seg.default_size ? SIZE_32 : SIZE_16;
      end else if (!i_code_seg.long_attr) begin
         o_mode.submode = SUB_COMPAT;
         o_mode.def_addr = i_code_seg.default_size ? SIZE_32 : SIZE_16;
      end else if (i_code_seg.default_size) begin
         o_mode.submode = SUB_RESERVED;
         o_mode.reserved = 1'b1;
         o_mode.def_addr = SIZE_64;
      end else begin
         o_mode.submode = SUB_64;
         o_mode.def_addr = SIZE_64;
      end
      o_mode.def_op = (o_mode.def_addr == SIZE_16) ? SIZE_16 : SIZE_32;
      if (o_mode.def_addr == SIZE_64) begin
         // Wide prefix beats the short one; address shrinks to 32 only
         o_mode.op_size = i_prefix.op_wide ? SIZE_64 : (i_prefix.op_short ? SIZE_16 : SIZE_32);
         o_mode.addr_size = i_prefix.addr_short ? SIZE_32 : SIZE_64;
      end else begin
         // Legacy style: short operand and address prefixes toggle 16 and 32
         o_mode.op_size = (i_prefix.op_short ^ (o_mode.def_op == SIZE_32)) ? SIZE_32 : SIZE_16;
         o_mode.addr_size = (i_prefix.addr_short ^ (o_mode.def_addr == SIZE_32)) ? SIZE_32 : SIZE_16;
      end
   end

endmodule : op_mode_decoder

`default_nettype wire

// File: src/long_mode_activation_control.sv
/*
 * Wide-mode activation control: enable, paging and address-extension bits
 * with consistency checks, the active status bit, sub-mode decode, page map
 * base and interrupt table register, all behind an AXI4-Lite slave.
 * Assumes one clock, asynchronous active-low reset and a bus master on the
 * same clock that keeps AXI4-Lite handshake rules.
 */
`timescale 1ns/1ns
`default_nettype none

module long_mode_activation_control
   import wide_mode_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // AXI4-Lite write address and data
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_awaddr,
   input wire logic [2:0] i_s_axi_awprot,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   // AXI4-Lite write response
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   // AXI4-Lite read
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [31:0] i_s_axi_araddr,
   input wire logic [2:0] i_s_axi_arprot,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   // Mode state toward the core
   output logic o_wide_mode_active,
   output logic o_paging_enable,
   output mode_info_t o_mode,
   output logic [63:0] o_page_map_base,
   output logic o_gp_fault
);

   // Control state
   logic wide_mode_enable_bit;
   logic paging_enable_bit;
   logic phys_addr_extension_bit;
   logic wide_mode_active_bit;
   code_seg_t code_seg;
   prefix_t prefix;
   logic [31:0] interrupt_table_reg;
   logic fault_sticky;
   logic [3:0] fault_cause;
   logic [15:0] fault_count;

   // Bus state
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic commit;
   logic [31:0] wr_val;

   // Check results
   logic next_enable;
   logic next_paging;
   logic next_pae;
   logic [3:0] check_fail;
   logic ctrl_fault;
   logic ctrl_commit;
   mode_info_t decoded;

   function automatic logic addr_mapped(input logic [31:0] a);
      return (a == OFS_CTRL) || (a == OFS_CODE_SEG) || (a == OFS_PREFIX) || (a == OFS_MODE) ||
             (a == OFS_PBASE_LO) || (a == OFS_PBASE_HI) || (a == OFS_INT_TABLE) || (a == OFS_FAULT);
   endfunction : addr_mapped

   function automatic logic [31:0] reg_word(input logic [31:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         OFS_CTRL: begin
            v[CTRL_ENABLE_POS] = wide_mode_enable_bit;
            v[CTRL_PAGING_POS] = paging_enable_bit;
            v[CTRL_PAE_POS] = phys_addr_extension_bit;
            v[CTRL_ACTIVE_POS] = wide_mode_active_bit;
         end
         OFS_CODE_SEG: begin
            v[CS_LONG_POS] = code_seg.long_attr;
            v[CS_DSIZE_POS] = code_seg.default_size;
         end
         OFS_PREFIX: begin
            v[PFX_SHORT_POS] = prefix.op_short;
            v[PFX_WIDE_POS] = prefix.op_wide;
            v[PFX_ADDR_POS] = prefix.addr_short;
         end
         OFS_MODE: begin
            v[MODE_SUB_LSB +: 2] = o_mode.submode;
            v[MODE_ADDR_LSB +: 2] = o_mode.addr_size;
            v[MODE_OP_LSB +: 2] = o_mode.op_size;
            v[MODE_RSV_POS] = o_mode.reserved;
            v[MODE_DEF_ADDR_LSB +: 2] = o_mode.def_addr;
            v[MODE_DEF_OP_LSB +: 2] = o_mode.def_op;
         end
         OFS_PBASE_LO: v = o_page_map_base[31:0];
         OFS_PBASE_HI: v = o_page_map_base[63:32];
         OFS_INT_TABLE: v = interrupt_table_reg;
         OFS_FAULT: begin
            v[FLT_STICKY_POS] = fault_sticky;
            v[FLT_CAUSE_LSB +: 4] = fault_cause;
            v[FLT_CODE_LSB +: 8] = GP_ERROR_CODE;
            v[FLT_COUNT_LSB +: 16] = fault_count;
         end
         default: v = 32'h0;
      endcase
      return v;
   endfunction : reg_word

   // Write address channel
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_held <= 1'b0;
         o_s_axi_awready <= 1'b1;
         aw_addr <= 32'h0;
      end else if (o_s_axi_awready && i_s_axi_awvalid) begin
         aw_held <= 1'b1;
         o_s_axi_awready <= 1'b0;
         aw_addr <= i_s_axi_awaddr;
      end else if (commit) begin
         aw_held <= 1'b0;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
         o_s_axi_awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_held <= 1'b0;
         o_s_axi_wready <= 1'b1;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (o_s_axi_wready && i_s_axi_wvalid) begin
         w_held <= 1'b1;
         o_s_axi_wready <= 1'b0;
         w_data <= i_s_axi_wdata;
         w_strb <= i_s_axi_wstrb;
      end else if (commit) begin
         w_held <= 1'b0;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
         o_s_axi_wready <= 1'b1;
      end
   end

   assign commit = aw_held && w_held && !o_s_axi_bvalid;
   // Procedural so the merge follows register state, not only the arguments
   always_comb begin
      wr_val = strobe_merge(reg_word(aw_addr), w_data, w_strb);
   end

   // Consistency checks on the attempted control bits
   always_comb begin
      next_enable = wr_val[CTRL_ENABLE_POS];
      next_paging = wr_val[CTRL_PAGING_POS];
      next_pae = wr_val[CTRL_PAE_POS];
      check_fail[0] = (next_enable != wide_mode_enable_bit) && paging_enable_bit;
      check_fail[1] = !paging_enable_bit && next_paging && next_enable && !next_pae;
      check_fail[2] = !paging_enable_bit && next_paging && next_enable && code_seg.long_attr;
      check_fail[3] = phys_addr_extension_bit && !next_pae && wide_mode_active_bit;
   end

   assign ctrl_commit = commit && (aw_addr == OFS_CTRL);
   assign ctrl_fault = ctrl_commit && (check_fail != 4'h0);

   // Write response
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= RESP_OKAY;
      end else if (commit) begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp <= (!addr_mapped(aw_addr) || ctrl_fault) ? RESP_SLVERR : RESP_OKAY;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   // Mode control bits; a failed check keeps all of them
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wide_mode_enable_bit <= 1'b0;
         paging_enable_bit <= 1'b0;
         phys_addr_extension_bit <= 1'b0;
         wide_mode_active_bit <= 1'b0;
      end else if (ctrl_commit && !ctrl_fault) begin
         wide_mode_enable_bit <= next_enable;
         paging_enable_bit <= next_paging;
         phys_addr_extension_bit <= next_pae;
         // Set on paging on with enable, cleared when paging drops
         wide_mode_active_bit <= next_paging && next_enable;
      end
   end

   // Code segment attributes and prefix overrides
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         code_seg <= '0;
         prefix <= '0;
      end else if (commit && (aw_addr == OFS_CODE_SEG)) begin
         code_seg.long_attr <= wr_val[CS_LONG_POS];
         code_seg.default_size <= wr_val[CS_DSIZE_POS];
      end else if (commit && (aw_addr == OFS_PREFIX)) begin
         prefix.op_short <= wr_val[PFX_SHORT_POS];
         prefix.op_wide <= wr_val[PFX_WIDE_POS];
         prefix.addr_short <= wr_val[PFX_ADDR_POS];
      end
   end

   // Page map base; upper word only writable once active
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_page_map_base <= RST_PAGE_BASE;
      end else if (commit && (aw_addr == OFS_PBASE_LO)) begin
         o_page_map_base[31:0] <= wr_val;
      end else if (commit && (aw_addr == OFS_PBASE_HI) && wide_mode_active_bit) begin
         o_page_map_base[63:32] <= wr_val;
      end
   end

   // Interrupt table reference; only software writes move it
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         interrupt_table_reg <= RST_INT_TABLE;
      end else if (commit && (aw_addr == OFS_INT_TABLE)) begin
         interrupt_table_reg <= wr_val;
      end
   end

   // Fault status; a new fault wins over a clear
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fault_sticky <= 1'b0;
         fault_cause <= 4'h0;
         fault_count <= RST_FAULT_COUNT;
         o_gp_fault <= 1'b0;
      end else begin
         o_gp_fault <= ctrl_fault;
         if (ctrl_fault) begin
            fault_sticky <= 1'b1;
            fault_cause <= check_fail;
            fault_count <= fault_count + 16'h1;
         end else if (commit && (aw_addr == OFS_FAULT) && w_strb[0] && w_data[FLT_STICKY_POS]) begin
            fault_sticky <= 1'b0;
         end
      end
   end

   op_mode_decoder u_decoder (
      .i_active(wide_mode_active_bit),
      .i_code_seg(code_seg),
      .i_prefix(prefix),
      .o_mode(decoded)
   );

   // Mode outputs toward the core
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mode <= '0;
         o_wide_mode_active <= 1'b0;
         o_paging_enable <= 1'b0;
      end else begin
         o_mode <= decoded;
         o_wide_mode_active <= wide_mode_active_bit;
         o_paging_enable <= paging_enable_bit;
      end
   end

   // Read channel
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h0;
         o_s_axi_rresp <= RESP_OKAY;
      end else if (o_s_axi_arready && i_s_axi_arvalid) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= reg_word(i_s_axi_araddr);
         o_s_axi_rresp <= addr_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end

endmodule : long_mode_activation_control

`default_nettype wire

// File: tb/lmac_sva.sv
/*
 * Assertions on the mode outputs and the fault pulse of the wide-mode
 * activation block. Bound to the top module from the bench; sees its ports only.
 */
`timescale 1ns/1ns
`default_nettype none

module lmac_sva
   import wide_mode_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Watched outputs
   input wire logic o_s_axi_bvalid,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_wide_mode_active,
   input wire logic o_paging_enable,
   input wire mode_info_t o_mode,
   input wire logic [63:0] o_page_map_base,
   input wire logic o_gp_fault
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_active_has_paging: assert property (o_wide_mode_active |-> o_paging_enable)
      else $error("active bit set without paging");
   a_fault_one_pulse: assert property (o_gp_fault |-> (o_s_axi_bvalid && o_s_axi_bresp == RESP_SLVERR) ##1 !o_gp_fault)
      else $error("fault pulse not tied to an error response");
   a_fault_keeps_state: assert property (o_gp_fault |=> $stable(o_paging_enable) && $stable(o_wide_mode_active))
      else $error("failed write changed the mode state");
   a_legacy_no_wide: assert property (!o_wide_mode_active |->
      o_mode.submode == SUB_LEGACY && o_mode.op_size != SIZE_64 && o_mode.addr_size != SIZE_64)
      else $error("wide sizes while inactive");
   a_legacy_even_sizes: assert property (!o_wide_mode_active |-> o_mode.def_op == o_mode.def_addr)
      else $error("legacy defaults differ");
   a_sub64_defaults: assert property (o_mode.submode == SUB_64 |->
      o_wide_mode_active && o_mode.def_addr == SIZE_64 && o_mode.def_op == SIZE_32)
      else $error("wrong 64-bit sub-mode defaults");
   a_sub64_addr_override: assert property (o_mode.submode == SUB_64 |-> o_mode.addr_size != SIZE_16)
      else $error("16-bit address in 64-bit sub-mode");
   a_reserved_flag: assert property (o_mode.reserved == (o_mode.submode == SUB_RESERVED))
      else $error("reserved flag disagrees with sub-mode");
   a_compat_sizes: assert property (o_mode.submode == SUB_COMPAT |->
      o_wide_mode_active && o_mode.def_op == o_mode.def_addr && o_mode.def_op != SIZE_64)
      else $error("wrong compatibility defaults");
   a_base_hi_legacy: assert property (!o_wide_mode_active |=> $stable(o_page_map_base[63:32]))
      else $error("upper page base changed while inactive");

   c_fault: cover property (o_gp_fault);
   c_sub64: cover property (o_mode.submode == SUB_64);
   c_reserved: cover property (o_mode.submode == SUB_RESERVED);
endmodule : lmac_sva

`default_nettype wire

// File: tb/test_long_mode_activation_control.sv
/*
 * Self-checking bench for the wide-mode activation block: AXI4-Lite register
 * tasks, control-bit transition table, sub-mode decode table.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module test_long_mode_activation_control;
   import wide_mode_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_arvalid = 1'b0;
   logic [31:0] i_s_axi_awaddr = 32'h0, i_s_axi_wdata = 32'h0, i_s_axi_araddr = 32'h0;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic o_wide_mode_active, o_paging_enable, o_gp_fault;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
   logic [31:0] o_s_axi_rdata, rd;
   logic [63:0] o_page_map_base;
   mode_info_t o_mode;
   logic gp;
   int errors = 0;
   int n_checks = 0;
   // Rows: code segment, control write, control read back
   logic [19:0] tbl [10] = '{20'h01001, 20'h03001, 20'h17001, 20'h07107, 20'h03107,
                             20'h06107, 20'h05005, 20'h04004, 20'h06006, 20'h07006};

   long_mode_activation_control u_long_mode_activation_control (
      .i_sys_clk, .i_rst_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
      .i_s_axi_awprot(3'h0), .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata,
      .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid, .i_s_axi_bready(1'b1), .o_s_axi_bresp,
      .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr, .i_s_axi_arprot(3'h0),
      .o_s_axi_rvalid, .i_s_axi_rready(1'b1), .o_s_axi_rdata, .o_s_axi_rresp,
      .o_wide_mode_active, .o_paging_enable, .o_mode, .o_page_map_base, .o_gp_fault
   );

   always #5 i_sys_clk = ~i_sys_clk;

   task automatic close_out;
      if (errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Ready lines are held high, so the answer is taken at the edge it is seen
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      gp = 1'b0;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_awaddr <= a;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_wdata <= d;
      do begin
         @(posedge i_sys_clk);
         n++;
         if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
         gp = gp | o_gp_fault;
      end while (!o_s_axi_bvalid && n < 40);
      resp = o_s_axi_bresp;
      if (n >= 40) errors++;
   endtask : wr

   task automatic rd_reg(input logic [31:0] a);
      int n;
      n = 0;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_araddr <= a;
      do begin
         @(posedge i_sys_clk);
         n++;
         if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      end while (!o_s_axi_rvalid && n < 40);
      rd = o_s_axi_rdata;
      resp = o_s_axi_rresp;
      if (n >= 40) errors++;
   endtask : rd_reg

   task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
      rd_reg(a);
      check({resp, rd}, {RESP_OKAY, e});
   endtask : chk_reg

   function automatic logic [31:0] mw(input logic [1:0] sub, input logic [1:0] ad, input logic [1:0] op,
                                      input logic rsv, input logic [1:0] da, input logic [1:0] dop);
      return {20'h0, dop, da, 1'b0, rsv, op, ad, sub};
   endfunction : mw

   // Status word and port carry the same decode in different packing
   task automatic mode_chk(input logic [31:0] cs, input logic [31:0] pfx, input logic [31:0] e);
      wr(OFS_CODE_SEG, cs);
      wr(OFS_PREFIX, pfx);
      chk_reg(OFS_MODE, e);
      check(o_mode, {e[6], e[11:8], e[5:0]});
   endtask : mode_chk

   task automatic run_ctrl(input int lo, input int hi);
      logic err;
      for (int i = lo; i <= hi; i++) begin
         err = tbl[i][7:0] !== {4'h0, tbl[i][15:12]};
         wr(OFS_CODE_SEG, {28'h0, tbl[i][19:16]});
         wr(OFS_CTRL, {28'h0, tbl[i][15:12]});
         check(gp, err);
         check(resp, err ? RESP_SLVERR : RESP_OKAY);
         chk_reg(OFS_CTRL, {20'h0, tbl[i][11:0]});
         check(o_wide_mode_active, tbl[i][8]);
         check(o_paging_enable, tbl[i][1]);
      end
   endtask : run_ctrl

   initial begin
      repeat (12) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      check({o_s_axi_awready, o_s_axi_wready, o_s_axi_arready}, 3'h7);
      chk_reg(OFS_CTRL, 32'h0);
      chk_reg(OFS_FAULT, 32'h0);
      check(o_mode, 11'h0);
      rd_reg(32'h0000_0040);
      check({resp, rd}, {RESP_SLVERR, 32'h0});
      wr(32'h0000_0040, 32'h1);
      check(resp, RESP_SLVERR);
      wr(OFS_INT_TABLE, 32'hcafe_0000);
      wr(OFS_PBASE_LO, 32'h1234_5000);
      wr(OFS_PBASE_HI, 32'h0000_00ab);
      check(o_page_map_base, 64'h0000_0000_1234_5000);
      run_ctrl(0, 0);
      mode_chk(32'h3, 32'h0, mw(SUB_LEGACY, SIZE_32, SIZE_32, 1'b0, SIZE_32, SIZE_32));
      mode_chk(32'h1, 32'h5, mw(SUB_LEGACY, SIZE_32, SIZE_32, 1'b0, SIZE_16, SIZE_16));
      run_ctrl(1, 3);
      chk_reg(OFS_INT_TABLE, 32'hcafe_0000);
      mode_chk(32'h0, 32'h0, mw(SUB_COMPAT, SIZE_16, SIZE_16, 1'b0, SIZE_16, SIZE_16));
      mode_chk(32'h2, 32'h5, mw(SUB_COMPAT, SIZE_16, SIZE_16, 1'b0, SIZE_32, SIZE_32));
      mode_chk(32'h1, 32'h0, mw(SUB_64, SIZE_64, SIZE_32, 1'b0, SIZE_64, SIZE_32));
      mode_chk(32'h1, 32'h7, mw(SUB_64, SIZE_32, SIZE_64, 1'b0, SIZE_64, SIZE_32));
      mode_chk(32'h1, 32'h1, mw(SUB_64, SIZE_64, SIZE_16, 1'b0, SIZE_64, SIZE_32));
      mode_chk(32'h3, 32'h0, mw(SUB_RESERVED, SIZE_64, SIZE_32, 1'b1, SIZE_64, SIZE_32));
      wr(OFS_PBASE_HI, 32'h0000_0009);
      check(o_page_map_base, 64'h0000_0009_1234_5000);
      run_ctrl(4, 9);
      chk_reg(OFS_FAULT, 32'h0005_0011);
      // Full activation from paged legacy mode
      wr(OFS_CTRL, 32'h4);
      wr(OFS_PBASE_LO, 32'h0000_8000);
      check(o_page_map_base, 64'h0000_0009_0000_8000);
      wr(OFS_CTRL, 32'h5);
      wr(OFS_CTRL, 32'h7);
      check(resp, RESP_OKAY);
      chk_reg(OFS_CTRL, 32'h107);
      check(o_wide_mode_active, 1'b1);
      wr(OFS_INT_TABLE, 32'hbeef_0000);
      chk_reg(OFS_INT_TABLE, 32'hbeef_0000);
      close_out;
   end

   // Whole run is a few hundred cycles
   initial begin
      #100000;
      errors++;
      close_out;
   end
endmodule : test_long_mode_activation_control

bind long_mode_activation_control lmac_sva u_lmac_sva (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_s_axi_bvalid(o_s_axi_bvalid),
   .o_s_axi_bresp(o_s_axi_bresp), .o_wide_mode_active(o_wide_mode_active),
   .o_paging_enable(o_paging_enable), .o_mode(o_mode), .o_page_map_base(o_page_map_base),
   .o_gp_fault(o_gp_fault)
);

`default_nettype wire
